// *** clk_sel_pkg.sv ***
/*
  Constants, register layouts and carrier types for the system clock
  select and suspend block.
  Assumes a special function register port on the clock clk.
*/
package clk_sel_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_SRC_SEL    = 8'h8F;
  localparam logic [7:0] ADDR_INT_CTRL   = 8'hA1;
  localparam logic [7:0] ADDR_COARSE     = 8'hA2;
  localparam logic [7:0] ADDR_FINE       = 8'h9E;
  localparam logic [7:0] ADDR_EXT_CTRL   = 8'hB1;
  localparam logic [7:0] ADDR_MULT_CTRL  = 8'hB3;

  // Source codes
  typedef enum logic [1:0] {
    SRC_INT  = 2'h0,
    SRC_EXT  = 2'h1,
    SRC_MULT = 2'h2,
    SRC_RSVD = 2'h3
  } clk_src_e;

  // Internal oscillator control layout
  localparam int          EN_HI        = 7;
  localparam int          EN_LO        = 6;
  localparam int          SUSPEND_BIT  = 5;
  localparam int          READY_BIT    = 4;
  localparam int          DIV_HI       = 2;
  localparam logic [1:0]  OSC_EN_RUN   = 2'h3;
  localparam logic [1:0]  OSC_EN_OFF   = 2'h0;
  localparam logic [2:0]  DIV_RESET    = 3'h0;
  localparam logic [2:0]  DIV_MAX_CODE = 3'h7;

  // External oscillator control layout
  localparam int          XTAL_VALID_BIT = 7;
  localparam int          EXT_EN_BIT     = 6;

  // Multiplier control layout
  localparam int          MULT_EXT_BIT   = 0;
  localparam int          MULT_X4_BIT    = 1;
  localparam int          MULT_SCALE_LO  = 2;
  localparam logic [2:0]  MULT_SCALE_MAX = 3'h5;

  // Settling and readiness, counted in sampled oscillator edges
  localparam logic [7:0]  XTAL_SETTLE_EDGES = 8'h40;
  localparam logic [3:0]  READY_EDGES       = 4'h4;

  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       use_ext;
    logic       times4;
    logic [2:0] scale;
  } mult_cfg_s;

endpackage

// *** level_sync.sv ***
/*
  Two flip-flop synchroniser for a group of levels.
  Assumes inputs are asynchronous to clk and only the second stage is read.
*/
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// *** pow2_divider.sv ***
/*
  Power-of-two divider of a sampled oscillator level.
  Assumes osc_level is already synchronised to clk.
*/
module pow2_divider (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Oscillator and setting
  input  wire logic       osc_level,
  input  wire logic [2:0] div_code,
  // Divided level and undivided rise strobe
  output logic            div_level,
  output logic            osc_rise
);
  import clk_sel_pkg::*;

  logic [6:0] count;
  logic       last;
  logic [2:0] shift;

  always_comb
  begin
    shift = DIV_MAX_CODE - div_code;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last  <= 1'b0;
      count <= '0;
    end
    else
    begin
      last <= osc_level;
      if (osc_level && !last)
        count <= count + 7'h01;
    end
  end

  // Code 111 passes the oscillator straight through
  always_comb
  begin
    osc_rise = osc_level && !last;
    if (shift == 3'h0)
      div_level = osc_level;
    else
      div_level = count[shift - 3'h1];
  end

endmodule

// *** clk_sel_top.sv ***
/*
  System clock source select, internal oscillator divider, trims and
  internal oscillator suspend with wake events.
  Assumes oscillator levels and wake inputs are asynchronous pins, the
  register port is synchronous to clk, and the analog oscillators and
  multiplier act on the enable and trim outputs.
*/
module clk_sel_top #(
  parameter logic [6:0] COARSE_TRIM_DEFAULT = 7'h40, // factory value stand-in
  parameter logic [5:0] FINE_TRIM_DEFAULT   = 6'h20  // factory value stand-in
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire clk_sel_pkg::sfr_req_s sfr_req,
  output logic [7:0]                 sfr_rdata,
  // Oscillator sources
  input  wire logic                  int_osc_in,
  input  wire logic                  ext_osc_in,
  input  wire logic                  mult_clk_in,
  // Wake events
  input  wire logic                  port0_match,
  input  wire logic                  port1_match,
  input  wire logic                  cmp0_enabled,
  input  wire logic                  cmp0_out,
  // Oscillator controls
  output logic                       int_osc_run,
  output logic [6:0]                 osc_coarse_trim,
  output logic [5:0]                 osc_fine_trim,
  output logic                       ext_osc_run,
  output clk_sel_pkg::mult_cfg_s     mult_cfg,
  // Clock outputs
  output logic                       system_clock,
  output logic                       periph_ext_clock,
  output logic                       core_clk_en,
  output logic                       cpu_suspended
);
  import clk_sel_pkg::*;

  typedef enum logic [2:0] {
    SW_RUN    = 3'h1,
    SW_PARK   = 3'h2,
    SW_ENGAGE = 3'h4
  } switch_e;

  // Registers
  clk_src_e   clock_source_field;
  logic [1:0] internal_osc_enable_field;
  logic       suspend;
  logic [2:0] internal_osc_divider;
  logic       ext_enable;
  logic       crystal_valid_flag;
  logic       osc_freq_ready_flag;

  // Synchronised pins
  logic [6:0] pins_sync;
  logic       int_lvl;
  logic       ext_lvl;
  logic       mult_lvl;
  logic       wake_p0;
  logic       wake_p1;
  logic       cmp_en;
  logic       cmp_lvl;
  logic       wake_event;

  logic       int_div_lvl;
  logic       int_rise;
  logic       ext_last;
  logic [7:0] settle_count;
  logic [3:0] ready_count;

  switch_e    sw_state;
  clk_src_e   active_src;
  clk_src_e   target_src;
  logic       src_level;
  logic       target_level;
  logic       next_system_clock;

  logic       wr_src;
  logic       wr_int;
  logic       wr_coarse;
  logic       wr_fine;
  logic       wr_ext;
  logic       wr_mult;

  level_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({int_osc_in, ext_osc_in, mult_clk_in, port0_match, port1_match,
                cmp0_enabled, cmp0_out}),
    .sync_out (pins_sync)
  );

  always_comb
  begin
    {int_lvl, ext_lvl, mult_lvl, wake_p0, wake_p1, cmp_en, cmp_lvl} = pins_sync;
    wake_event = wake_p0 || wake_p1 || (cmp_en && !cmp_lvl);
  end

  pow2_divider u_int_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .osc_level (int_lvl),
    .div_code  (internal_osc_divider),
    .div_level (int_div_lvl),
    .osc_rise  (int_rise)
  );

  // Write decode
  always_comb
  begin
    wr_src    = sfr_req.wr && (sfr_req.addr == ADDR_SRC_SEL);
    wr_int    = sfr_req.wr && (sfr_req.addr == ADDR_INT_CTRL);
    wr_coarse = sfr_req.wr && (sfr_req.addr == ADDR_COARSE);
    wr_fine   = sfr_req.wr && (sfr_req.addr == ADDR_FINE);
    wr_ext    = sfr_req.wr && (sfr_req.addr == ADDR_EXT_CTRL);
    wr_mult   = sfr_req.wr && (sfr_req.addr == ADDR_MULT_CTRL);
  end

  // Source select; the reserved code is refused and the old source kept
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clock_source_field <= SRC_INT;
    else if (wr_src && (sfr_req.wdata[1:0] != SRC_RSVD))
      clock_source_field <= clk_src_e'(sfr_req.wdata[1:0]);
  end

  // Internal oscillator control; wake clears suspend
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      internal_osc_enable_field <= OSC_EN_RUN;
      suspend                   <= 1'b0;
      internal_osc_divider      <= DIV_RESET;
    end
    else
    begin
      if (wr_int)
      begin
        internal_osc_enable_field <= sfr_req.wdata[EN_HI:EN_LO];
        internal_osc_divider      <= sfr_req.wdata[DIV_HI:0];
      end
      if (wr_int && sfr_req.wdata[SUSPEND_BIT])
        suspend <= 1'b1;
      else if (wake_event)
        suspend <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      osc_coarse_trim <= COARSE_TRIM_DEFAULT;
      osc_fine_trim   <= FINE_TRIM_DEFAULT;
    end
    else
    begin
      if (wr_coarse)
        osc_coarse_trim <= sfr_req.wdata[6:0];
      if (wr_fine)
        osc_fine_trim <= sfr_req.wdata[5:0];
    end
  end

  // Oscillator run controls
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      int_osc_run <= 1'b1;
      ext_osc_run <= 1'b0;
    end
    else
    begin
      int_osc_run <= (internal_osc_enable_field == OSC_EN_RUN) && !suspend;
      ext_osc_run <= ext_enable;
    end
  end

  // Multiplier setup; out-of-range scale codes are refused
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mult_cfg <= '0;
    else if (wr_mult && (sfr_req.wdata[MULT_SCALE_LO+2:MULT_SCALE_LO] <= MULT_SCALE_MAX))
    begin
      mult_cfg.use_ext <= sfr_req.wdata[MULT_EXT_BIT];
      mult_cfg.times4  <= sfr_req.wdata[MULT_X4_BIT];
      mult_cfg.scale   <= sfr_req.wdata[MULT_SCALE_LO+2:MULT_SCALE_LO];
    end
  end

  // External oscillator enable and settling
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_enable         <= 1'b0;
      ext_last           <= 1'b0;
      settle_count       <= ZERO_BYTE;
      crystal_valid_flag <= 1'b0;
    end
    else
    begin
      ext_last <= ext_lvl;
      if (wr_ext)
        ext_enable <= sfr_req.wdata[EXT_EN_BIT];
      if (!ext_enable)
      begin
        settle_count       <= ZERO_BYTE;
        crystal_valid_flag <= 1'b0;
      end
      else if (settle_count == XTAL_SETTLE_EDGES)
        crystal_valid_flag <= 1'b1;
      else if (ext_lvl && !ext_last)
        settle_count <= settle_count + 8'h01;
    end
  end

  // Frequency ready needs a few edges after the oscillator starts
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ready_count         <= '0;
      osc_freq_ready_flag <= 1'b0;
    end
    else if (!int_osc_run)
    begin
      ready_count         <= '0;
      osc_freq_ready_flag <= 1'b0;
    end
    else if (ready_count == READY_EDGES)
      osc_freq_ready_flag <= 1'b1;
    else if (int_rise)
      ready_count <= ready_count + 4'h1;
  end

  // Peripherals keep the external clock whatever the system source
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      periph_ext_clock <= 1'b0;
    else
      periph_ext_clock <= ext_lvl;
  end

  function automatic logic pick(input clk_src_e s, input logic i, input logic e,
                                input logic m);
    logic r;
    r = 1'b0;
    unique case (s)
      SRC_INT:  r = i;
      SRC_EXT:  r = e;
      SRC_MULT: r = m;
      default:  r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb
  begin
    src_level    = pick(active_src, int_div_lvl, ext_lvl, mult_lvl);
    target_level = pick(target_src, int_div_lvl, ext_lvl, mult_lvl);
  end

  // Glitch-free changeover: park low, then join the new source at its low
  // phase. Costs up to one period of each clock but no runt pulse.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_state   <= SW_RUN;
      active_src <= SRC_INT;
      target_src <= SRC_INT;
    end
    else
    begin
      unique case (sw_state)
        SW_RUN:
        begin
          if (clock_source_field != active_src)
          begin
            target_src <= clock_source_field;
            sw_state   <= SW_PARK;
          end
        end
        SW_PARK:
        begin
          if (!system_clock)
            sw_state <= SW_ENGAGE;
        end
        SW_ENGAGE:
        begin
          if (!target_level)
          begin
            active_src <= target_src;
            sw_state   <= SW_RUN;
          end
        end
        default: sw_state <= SW_RUN;
      endcase
    end
  end

  always_comb
  begin
    if (sw_state == SW_RUN)
      next_system_clock = src_level;
    else if (sw_state == SW_PARK)
      next_system_clock = system_clock && src_level;
    else
      next_system_clock = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      system_clock <= 1'b0;
    else
      system_clock <= next_system_clock;
  end

  // Core gating while suspended with the internal source active; CPU holds its place and resumes in line
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      core_clk_en   <= 1'b1;
      cpu_suspended <= 1'b0;
    end
    else
    begin
      core_clk_en   <= !(suspend && (active_src == SRC_INT));
      cpu_suspended <= suspend && (active_src == SRC_INT);
    end
  end

  // Register reads, answered the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sfr_rdata <= ZERO_BYTE;
    else if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        ADDR_SRC_SEL:   sfr_rdata <= {6'h00, clock_source_field};
        ADDR_INT_CTRL:  sfr_rdata <= {internal_osc_enable_field, suspend,
                                      osc_freq_ready_flag, 1'b0,
                                      internal_osc_divider};
        ADDR_COARSE:    sfr_rdata <= {1'b0, osc_coarse_trim};
        ADDR_FINE:      sfr_rdata <= {2'h0, osc_fine_trim};
        ADDR_EXT_CTRL:  sfr_rdata <= {crystal_valid_flag, ext_enable, 6'h00};
        ADDR_MULT_CTRL: sfr_rdata <= {3'h0, mult_cfg.scale, mult_cfg.times4,
                                      mult_cfg.use_ext};
        default:        sfr_rdata <= ZERO_BYTE;
      endcase
    end
  end

endmodule

// *** clk_sel_asserts.sv ***
/*
  Checker for the clock select block, bound to clk_sel_top.
  Assumes every port is sampled on the rising edge of clk.
*/
module clk_sel_asserts
  import clk_sel_pkg::*;
#(
  parameter logic [6:0] COARSE_TRIM_DEFAULT = 7'h40,
  parameter logic [5:0] FINE_TRIM_DEFAULT   = 6'h20
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Register port
  input wire clk_sel_pkg::sfr_req_s  sfr_req,
  input wire logic [7:0]             sfr_rdata,
  // Source and wake pins
  input wire logic                   ext_osc_in,
  input wire logic                   port0_match,
  input wire logic                   port1_match,
  input wire logic                   cmp0_enabled,
  input wire logic                   cmp0_out,
  // Controls and clocks
  input wire logic                   int_osc_run,
  input wire logic [6:0]             osc_coarse_trim,
  input wire logic [5:0]             osc_fine_trim,
  input wire clk_sel_pkg::mult_cfg_s mult_cfg,
  input wire logic                   periph_ext_clock,
  input wire logic                   core_clk_en,
  input wire logic                   cpu_suspended
);
  logic wake_any;
  assign wake_any = port0_match | port1_match | (cmp0_enabled & ~cmp0_out);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_reset_state:
    assert property ($rose(rst_n) |-> int_osc_run && core_clk_en
      && osc_coarse_trim == COARSE_TRIM_DEFAULT && osc_fine_trim == FINE_TRIM_DEFAULT)
    else $error("state after reset wrong");
  chk_src_upper:
    assert property (sfr_req.rd && sfr_req.addr == ADDR_SRC_SEL |=> sfr_rdata[7:2] == 6'h00)
    else $error("source register upper bits set");
  chk_coarse_read:
    assert property (sfr_req.rd && sfr_req.addr == ADDR_COARSE
      |=> sfr_rdata == {1'h0, $past(osc_coarse_trim)})
    else $error("coarse trim read wrong");
  chk_fine_read:
    assert property (sfr_req.rd && sfr_req.addr == ADDR_FINE
      |=> sfr_rdata == {2'h0, $past(osc_fine_trim)})
    else $error("fine trim read wrong");
  chk_suspend_stop:
    assert property ((!wake_any)[*3] ##0 (sfr_req.wr && sfr_req.addr == ADDR_INT_CTRL
      && sfr_req.wdata[SUSPEND_BIT]) |-> ##2 !int_osc_run)
    else $error("oscillator not stopped by suspend");
  chk_core_gate:
    assert property (cpu_suspended == !core_clk_en && (core_clk_en || !int_osc_run))
    else $error("core gated without suspended oscillator");
  chk_wake_resume:
    assert property (cpu_suspended && wake_any |-> ##[1:6] !cpu_suspended)
    else $error("wake event did not resume");
  chk_ext_follow:
    assert property ($rose(periph_ext_clock)
      |-> $past(ext_osc_in, 2) || $past(ext_osc_in, 3) || $past(ext_osc_in, 4))
    else $error("peripheral clock not from external source");
  chk_mult_scale:
    assert property (mult_cfg.scale <= MULT_SCALE_MAX)
    else $error("multiplier scale out of range");
endmodule

bind clk_sel_top clk_sel_asserts #(
  .COARSE_TRIM_DEFAULT(COARSE_TRIM_DEFAULT),
  .FINE_TRIM_DEFAULT  (FINE_TRIM_DEFAULT)
) u_chk (
  .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .ext_osc_in(ext_osc_in), .port0_match(port0_match), .port1_match(port1_match),
  .cmp0_enabled(cmp0_enabled), .cmp0_out(cmp0_out), .int_osc_run(int_osc_run),
  .osc_coarse_trim(osc_coarse_trim), .osc_fine_trim(osc_fine_trim), .mult_cfg(mult_cfg),
  .periph_ext_clock(periph_ext_clock), .core_clk_en(core_clk_en),
  .cpu_suspended(cpu_suspended)
);

// *** osc_sources.sv ***
/*
  Behavioural oscillator sources and clock multiplier output.
  Assumes the run inputs come from the block's oscillator controls.
*/
// Half periods are multiples of 20 ns and above the 100 ns clk period, so no
// edge meets a rising clk edge and every phase is seen by the synchroniser.
module osc_sources #(
  parameter int INT_HALF  = 120,
  parameter int EXT_HALF  = 180,
  parameter int MULT_HALF = 140
) (
  // Enables
  input  wire logic int_osc_run,
  input  wire logic ext_osc_run,
  // Levels
  output logic      int_osc_in,
  output logic      ext_osc_in,
  output logic      mult_clk_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stopped oscillator rests low, not at its last phase
  initial
  begin
    int_osc_in = 1'b0;
    ext_osc_in = 1'b0;
    mult_clk_in = 1'b0;
  end
  always
  begin
    #INT_HALF;
    int_osc_in = (int_osc_run === 1'b1) ? !int_osc_in : 1'b0;
  end
  always
  begin
    #EXT_HALF;
    ext_osc_in = (ext_osc_run === 1'b1) ? !ext_osc_in : 1'b0;
  end
  // Multiplier needs a running reference
  always
  begin
    #MULT_HALF;
    mult_clk_in = ((int_osc_run | ext_osc_run) === 1'b1) ? !mult_clk_in : 1'b0;
  end
endmodule

// *** clk_sel_top_test.sv ***
/*
  Self-checking bench for clk_sel_top with an oscillator model.
  Assumes the checker is bound to the design and clk runs at 10 MHz.
*/
module clk_sel_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_sel_pkg::*;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  sfr_req_s   req = '0;
  logic [7:0] rdata;
  logic [6:0] osc_coarse_trim;
  logic [5:0] osc_fine_trim;
  mult_cfg_s  mult_cfg;
  logic       int_osc_in, ext_osc_in, mult_clk_in, int_osc_run, ext_osc_run;
  logic       system_clock, periph_ext_clock, core_clk_en, cpu_suspended;
  logic       port0_match = 1'b0, port1_match = 1'b0, cmp0_enabled = 1'b0, cmp0_out = 1'b1;
  int         failures = 0, cmp_count = 0;

  always #50 clk = ~clk;

  clk_sel_top uut (
    .clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata), .int_osc_in(int_osc_in),
    .ext_osc_in(ext_osc_in), .mult_clk_in(mult_clk_in), .port0_match(port0_match),
    .port1_match(port1_match), .cmp0_enabled(cmp0_enabled), .cmp0_out(cmp0_out),
    .int_osc_run(int_osc_run), .osc_coarse_trim(osc_coarse_trim),
    .osc_fine_trim(osc_fine_trim), .ext_osc_run(ext_osc_run), .mult_cfg(mult_cfg),
    .system_clock(system_clock), .periph_ext_clock(periph_ext_clock),
    .core_clk_en(core_clk_en), .cpu_suspended(cpu_suspended));

  osc_sources model (
    .int_osc_run(int_osc_run), .ext_osc_run(ext_osc_run), .int_osc_in(int_osc_in),
    .ext_osc_in(ext_osc_in), .mult_clk_in(mult_clk_in));

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd_raw(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    d = rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd_raw(a, d);
    chk(what, exp, d);
  endtask

  // Bounded wait; running out ends the run with a mismatch
  task automatic wait_for(ref logic sig, input logic val, input int lim);
    int n;
    n = 0;
    while (sig !== val && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("wait", {7'h00, val}, {7'h00, sig});
    if (sig !== val)
      results();
  endtask

  task automatic toggles(ref logic sig, input int cyc, output int t);
    logic last;
    t = 0;
    last = sig;
    repeat (cyc)
    begin
      @(negedge clk);
      t += int'(sig !== last);
      last = sig;
    end
  endtask

  // One millisecond of clk: the wait software owes the crystal before polling
  localparam int MS_CYCLES = 10000;

  initial
  begin
    int t;
    logic [7:0] d;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    toggles(system_clock, 64, t);
    chk("div128", 8'h01, {7'h00, t <= 1});
    rd(ADDR_SRC_SEL, 8'h00, "source");
    rd(ADDR_INT_CTRL, 8'hD0, "int ctrl");
    rd(ADDR_COARSE, 8'h40, "coarse");
    rd(ADDR_FINE, 8'h20, "fine");
    rd(8'h00, 8'h00, "unmapped");
    $display("test reset done");
    wr(ADDR_COARSE, 8'hFF);
    rd(ADDR_COARSE, 8'h7F, "coarse rw");
    chk("coarse out", 8'h7F, {1'h0, osc_coarse_trim});
    wr(ADDR_FINE, 8'hFF);
    rd(ADDR_FINE, 8'h3F, "fine rw");
    chk("fine out", 8'h3F, {2'h0, osc_fine_trim});
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_INT_CTRL, {5'h18, 3'(c)});
      rd(ADDR_INT_CTRL, {5'h1A, 3'(c)}, "divider");
    end
    toggles(system_clock, 64, t);
    chk("div1", 8'h01, {7'h00, t > 16});
    wr(ADDR_INT_CTRL, 8'h07);
    // The run control is registered one edge behind the enable field
    @(negedge clk);
    chk("osc off", 8'h00, {7'h00, int_osc_run});
    wr(ADDR_INT_CTRL, 8'hC7);
    $display("test internal done");
    wr(ADDR_EXT_CTRL, 8'h40);
    rd(ADDR_EXT_CTRL, 8'h40, "not settled");
    chk("ext run", 8'h01, {7'h00, ext_osc_run});
    repeat (MS_CYCLES) @(negedge clk);
    t = 0;
    do
    begin
      rd_raw(ADDR_EXT_CTRL, d);
      t++;
    end while (d[7] !== 1'b1 && t < 200);
    chk("crystal valid", 8'hC0, d);
    if (d[7] !== 1'b1)
      results();
    toggles(periph_ext_clock, 32, t);
    chk("periph ext", 8'h01, {7'h00, t > 4});
    for (int s = 0; s < 6; s++)
    begin
      wr(ADDR_MULT_CTRL, {3'h0, 3'(s), 2'h3});
      rd(ADDR_MULT_CTRL, {3'h0, 3'(s), 2'h3}, "mult");
    end
    wr(ADDR_MULT_CTRL, 8'h1B);
    rd(ADDR_MULT_CTRL, 8'h17, "mult scale 6");
    chk("mult cfg", 8'h1D, {3'h0, mult_cfg});
    wr(ADDR_SRC_SEL, 8'hFD);
    rd(ADDR_SRC_SEL, 8'h01, "source ext");
    toggles(system_clock, 64, t);
    chk("system_clock ext", 8'h01, {7'h00, t > 8});
    // No flash timing to set: the modelled multiplier stays below 25 MHz
    wr(ADDR_SRC_SEL, 8'h02);
    wr(ADDR_SRC_SEL, 8'h03);
    rd(ADDR_SRC_SEL, 8'h02, "source reserved");
    toggles(system_clock, 64, t);
    chk("system_clock mult", 8'h01, {7'h00, t > 8});
    wr(ADDR_SRC_SEL, 8'h00);
    rd(ADDR_SRC_SEL, 8'h00, "source int");
    $display("test source done");
    for (int e = 0; e < 3; e++)
    begin
      wr(ADDR_INT_CTRL, 8'hE7);
      wait_for(cpu_suspended, 1'b1, 6);
      chk("osc stop", 8'h00, {7'h00, int_osc_run});
      cmp0_enabled = 1'b1;
      repeat (8) @(negedge clk);
      chk("no wake", 8'h01, {7'h00, cpu_suspended});
      port0_match = (e == 0);
      port1_match = (e == 1);
      cmp0_out = (e != 2);
      wait_for(cpu_suspended, 1'b0, 8);
      port0_match = 1'b0;
      port1_match = 1'b0;
      cmp0_enabled = 1'b0;
      cmp0_out = 1'b1;
      repeat (16) @(negedge clk);
      rd(ADDR_INT_CTRL, 8'hD7, "after wake");
    end
    wr(ADDR_SRC_SEL, 8'h01);
    // Let the changeover finish before suspending the internal oscillator
    repeat (8) @(negedge clk);
    wr(ADDR_INT_CTRL, 8'hE7);
    repeat (4) @(negedge clk);
    chk("core ext", 8'h01, {7'h00, core_clk_en});
    port1_match = 1'b1;
    wait_for(int_osc_run, 1'b1, 8);
    port1_match = 1'b0;
    wr(ADDR_SRC_SEL, 8'h00);
    $display("test suspend done");
    results();
  end
endmodule
